// *** design/usr_map.svh ***
`ifndef USR_MAP_SVH
`define USR_MAP_SVH

// ****************************************************************
// region bounds
// ****************************************************************
`define USR_REGION_TOP 9'h1ff
`define USR_EXT_LO 16'hffd0
`define USR_EXT_HI 16'hffdf

// ****************************************************************
// register addresses
// ****************************************************************
`define USR_RT_MODE_0 16'hff86
`define USR_RT_CTRL_0 16'hff87
`define USR_FLASH_CTRL 16'hff89
`define USR_INV_CTRL 16'hff90
`define USR_INV_MODE 16'hff91
`define USR_CMP_0 16'hff92
`define USR_CMP_1 16'hff94
`define USR_CMP_2 16'hff96
`define USR_CMP_3 16'hff98
`define USR_DEAD_TIME 16'hff9a
`define USR_RT_BUF_1_LO 16'hff9c
`define USR_RT_BUF_1_HI 16'hff9d
`define USR_RT_MODE_1 16'hff9e
`define USR_RT_CTRL_1 16'hff9f
`define USR_ASER_MODE_0 16'hffa0
`define USR_ASER_STATE_0 16'hffa1
`define USR_BAUD_CTRL_0 16'hffa2
`define USR_ASER_MODE_1 16'hffa8
`define USR_ASER_STATE_1 16'hffa9
`define USR_BAUD_CTRL_1 16'hffaa
`define USR_CSER_MODE 16'hffb0
`define USR_DC_CTRL_0 16'hffb8
`define USR_DC_CTRL_1 16'hffbc
`define USR_IRQ_REQ_0_LO 16'hffe0
`define USR_IRQ_REQ_0_HI 16'hffe1
`define USR_IRQ_REQ_1_LO 16'hffe2
`define USR_IRQ_MASK_0_LO 16'hffe4
`define USR_IRQ_MASK_0_HI 16'hffe5
`define USR_IRQ_MASK_1_LO 16'hffe6
`define USR_IRQ_PRIO_0_LO 16'hffe8
`define USR_IRQ_PRIO_0_HI 16'hffe9
`define USR_IRQ_PRIO_1_LO 16'hffea
`define USR_MEM_SIZE 16'hfff0
`define USR_XRAM_SIZE 16'hfff4
`define USR_MEM_WAIT 16'hfff8
`define USR_WDT_MODE 16'hfff9
`define USR_OSC_SELECT 16'hfffa
`define USR_CLK_CTRL 16'hfffb

// ****************************************************************
// reset values and field positions
// ****************************************************************
`define USR_RST_ZERO 8'h00
`define USR_RST_ONES 8'hff
`define USR_RST_FLASH_CTRL 8'h08
`define USR_RST_MEM_SIZE 8'hcf
`define USR_RST_XRAM_SIZE 8'h0c
`define USR_RST_MEM_WAIT 8'h10
`define USR_RST_OSC_SELECT 8'h04
`define USR_RST_CLK_CTRL 8'h04
`define USR_FLASH_VPP_BIT 2

`endif

// *** design/usr_pkg.sv ***
package usr_pkg;

    // access width requested by the core
    typedef enum logic [1:0] {
        USR_BIT = 2'h0,
        USR_BYTE = 2'h1,
        USR_WORD = 2'h3
    } usr_size_e;

    // per-byte decode attributes
    typedef struct packed {
        logic map;
        logic rd;
        logic wr;
        logic bit_ok;
        logic word_ok;
    } usr_attr_s;

endpackage : usr_pkg

// *** design/usr_regs.sv ***
`timescale 1ns/100ps
`include "usr_map.svh"

// Summary of operation
// - compare registers 0 to 2 are 16-bit, reset to zero, byte or word.
// - compare register 3 resets to 00ffh, same access widths.
// - dead-time reload is write-only, byte-only, resets to all ones.
// - flash control resets to 08h and bit 2 reads the vpp pin level.
// - ffd0h-ffdfh goes to external memory on direct byte or bit addressing only.
// - both serial status registers are read-only, byte-only.
// - request flags reset to zero, group 0 also word accessible.
// - mask flags reset to all ones, group 0 also word accessible.
// - priority flags reset to all ones, group 0 word accessible.
// - memory size register resets to cfh, byte-only, software tunes it.
// - expansion ram size resets to 0ch, byte-only, software tunes it.
// - wait resets 10h, watchdog 00h, oscillator select 04h.
// - baud control is byte-only, mode and control allow bit access.
// - real-time output registers are read/write, bit/byte, reset zero.
// - inverter control and mode are read/write, bit/byte, reset zero.
module usr_regs (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [15:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire usr_pkg::usr_size_e size_i,
    input wire logic [2:0] bit_sel_i,
    input wire logic sfr_mode_i,
    input wire logic vpp_level_i,
    input wire logic [7:0] async_state_0_i,
    input wire logic [7:0] async_state_1_i,
    input wire logic [7:0] ext_rdata_i,
    output logic [15:0] rdata_o,
    output logic rvalid_o,
    output logic err_o,
    output logic ext_req_o,
    output logic ext_we_o,
    output logic [15:0] ext_addr_o,
    output logic [7:0] ext_wdata_o,
    output logic [7:0] ext_wmask_o,
    output logic [7:0] dead_time_o,
    output logic [7:0] mem_size_o,
    output logic [7:0] xram_size_o,
    output logic [7:0] mem_wait_o,
    output logic [7:0] wdt_mode_o
);

    // ****************************************************************
    // decode functions
    // ****************************************************************

    // attributes: map, rd, wr, bit, word
    function automatic usr_pkg::usr_attr_s usr_attr(input logic [15:0] a);
        usr_pkg::usr_attr_s r;
        r = '0;
        case (a)
            `USR_RT_MODE_0, `USR_RT_CTRL_0, `USR_RT_BUF_1_LO,
            `USR_RT_BUF_1_HI, `USR_RT_MODE_1, `USR_RT_CTRL_1:
                r = 5'b11110;
            `USR_INV_CTRL, `USR_INV_MODE:
                r = 5'b11110;
            `USR_FLASH_CTRL, `USR_ASER_MODE_0, `USR_ASER_MODE_1,
            `USR_CSER_MODE, `USR_DC_CTRL_0, `USR_DC_CTRL_1,
            `USR_IRQ_REQ_0_HI, `USR_IRQ_REQ_1_LO, `USR_IRQ_MASK_0_HI,
            `USR_IRQ_MASK_1_LO, `USR_IRQ_PRIO_0_HI, `USR_IRQ_PRIO_1_LO,
            `USR_WDT_MODE, `USR_CLK_CTRL:
                r = 5'b11110;
            `USR_CMP_0, `USR_CMP_1, `USR_CMP_2, `USR_CMP_3:
                r = 5'b11101;
            `USR_IRQ_REQ_0_LO:
                r = 5'b11111;
            `USR_IRQ_MASK_0_LO:
                r = 5'b11111;
            `USR_IRQ_PRIO_0_LO:
                r = 5'b11111;
            `USR_DEAD_TIME:
                r = 5'b10100;
            `USR_ASER_STATE_0, `USR_ASER_STATE_1:
                r = 5'b11000;
            `USR_BAUD_CTRL_0, `USR_BAUD_CTRL_1, `USR_MEM_SIZE,
            `USR_XRAM_SIZE, `USR_MEM_WAIT, `USR_OSC_SELECT:
                r = 5'b11100;
            default: begin
                // upper bytes of the compare words: byte only
                if (a[15:4] == 12'hff9 && a[0] && a[3:1] >= 3'h1
                    && a[3:1] <= 3'h4) begin
                    r = 5'b11100;
                end else begin
                    r = '0;
                end
            end
        endcase
        return r;
    endfunction : usr_attr

    // reset value of each byte in the region
    function automatic logic [7:0] usr_rst(input logic [15:0] a);
        case (a)
            `USR_FLASH_CTRL: return `USR_RST_FLASH_CTRL;
            `USR_CMP_3: return `USR_RST_ONES;
            `USR_DEAD_TIME: return `USR_RST_ONES;
            `USR_IRQ_MASK_0_LO, `USR_IRQ_MASK_0_HI,
            `USR_IRQ_MASK_1_LO: return `USR_RST_ONES;
            `USR_IRQ_PRIO_0_LO, `USR_IRQ_PRIO_0_HI,
            `USR_IRQ_PRIO_1_LO: return `USR_RST_ONES;
            `USR_MEM_SIZE: return `USR_RST_MEM_SIZE;
            `USR_XRAM_SIZE: return `USR_RST_XRAM_SIZE;
            `USR_MEM_WAIT: return `USR_RST_MEM_WAIT;
            `USR_OSC_SELECT: return `USR_RST_OSC_SELECT;
            `USR_CLK_CTRL: return `USR_RST_CLK_CTRL;
            default: return `USR_RST_ZERO;
        endcase
    endfunction : usr_rst

    // ****************************************************************
    // request decode
    // ****************************************************************
    logic [7:0] mem [0:127];
    usr_pkg::usr_attr_s attr;
    logic [6:0] off;
    logic in_region;
    logic is_ext;
    logic is_bit;
    logic is_word;
    logic width_ok;
    logic wr_ok;
    logic rd_ok;
    logic ext_ok;
    logic refused;
    logic [7:0] wmask;
    logic [7:0] wbyte;
    logic [7:0] lo_b;
    logic [7:0] hi_b;

    // widths and directions checked against the byte attributes
    always_comb begin
        off = addr_i[6:0];
        in_region = addr_i[15:7] == `USR_REGION_TOP;
        attr = usr_attr(addr_i);
        is_ext = addr_i >= `USR_EXT_LO && addr_i <= `USR_EXT_HI;
        is_bit = size_i == usr_pkg::USR_BIT;
        is_word = size_i == usr_pkg::USR_WORD;
        width_ok = size_i == usr_pkg::USR_BYTE
            || (is_bit && attr.bit_ok)
            || (is_word && attr.word_ok && !addr_i[0]);
        wr_ok = wr_i && in_region && attr.map && attr.wr && width_ok;
        rd_ok = rd_i && in_region && attr.map && attr.rd && width_ok;
        // sfr addressing never reaches the external window
        ext_ok = is_ext && !sfr_mode_i && !is_word;
        refused = (wr_i && in_region && attr.map && !wr_ok)
            || (rd_i && in_region && attr.map && !rd_ok)
            || ((wr_i || rd_i) && is_ext && !ext_ok);
        wmask = is_bit ? 8'h01 << bit_sel_i : 8'hff;
        wbyte = is_bit ? {8{wdata_i[0]}} : wdata_i[7:0];
    end

    // read view: pins override stored bits where the hardware says so
    always_comb begin
        lo_b = mem[off];
        hi_b = mem[off + 7'h01];
        if (addr_i == `USR_FLASH_CTRL) begin
            lo_b[`USR_FLASH_VPP_BIT] = vpp_level_i;
        end
        if (addr_i == `USR_ASER_STATE_0) begin
            lo_b = async_state_0_i;
        end
        if (addr_i == `USR_ASER_STATE_1) begin
            lo_b = async_state_1_i;
        end
    end

    // ****************************************************************
    // register storage
    // ****************************************************************

    // bytes that are never written keep their constant and fold away
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < 128; i++) begin
                mem[i] <= usr_rst({9'h1ff, 7'(i)});
            end
        end else if (wr_ok) begin
            // a bit write merges into the stored byte
            mem[off] <= (mem[off] & ~wmask) | (wbyte & wmask);
            if (is_word) begin
                mem[off + 7'h01] <= wdata_i[15:8];
            end
        end
    end

    // ****************************************************************
    // read answer and external window
    // ****************************************************************
    logic ext_rd_pend_reg;
    logic ext_bit_reg;
    logic [2:0] ext_sel_reg;

    // external forward is registered, so its answer comes a cycle later
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ext_req_o <= 1'b0;
            ext_we_o <= 1'b0;
            ext_addr_o <= 16'h0000;
            ext_wdata_o <= 8'h00;
            ext_wmask_o <= 8'h00;
            ext_rd_pend_reg <= 1'b0;
            ext_bit_reg <= 1'b0;
            ext_sel_reg <= 3'h0;
        end else begin
            ext_req_o <= ext_ok && (wr_i || rd_i);
            ext_we_o <= ext_ok && wr_i;
            ext_addr_o <= addr_i;
            ext_wdata_o <= wbyte;
            ext_wmask_o <= wmask;
            ext_rd_pend_reg <= ext_ok && rd_i && !wr_i;
            ext_bit_reg <= is_bit;
            ext_sel_reg <= bit_sel_i;
        end
    end

    // read data, valid strobe and refusal strobe
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_o <= 16'h0000;
            rvalid_o <= 1'b0;
            err_o <= 1'b0;
        end else begin
            err_o <= refused;
            // a refused read answers with err_o alone, never with rvalid_o
            rvalid_o <= (rd_i && !wr_i && !is_ext && !refused)
                || ext_rd_pend_reg;
            if (ext_rd_pend_reg) begin
                rdata_o <= ext_bit_reg ? {15'h0000, ext_rdata_i[ext_sel_reg]}
                    : {8'h00, ext_rdata_i};
            end else if (!rd_ok) begin
                rdata_o <= 16'h0000;
            end else if (is_bit) begin
                rdata_o <= {15'h0000, lo_b[bit_sel_i]};
            end else if (is_word) begin
                rdata_o <= {hi_b, lo_b};
            end else begin
                rdata_o <= {8'h00, lo_b};
            end
        end
    end

    // ****************************************************************
    // configuration outputs
    // ****************************************************************
    // taken straight from the storage flops
    assign dead_time_o = mem[7'h1a];
    assign mem_size_o = mem[7'h70];
    assign xram_size_o = mem[7'h74];
    assign mem_wait_o = mem[7'h78];
    assign wdt_mode_o = mem[7'h79];

endmodule : usr_regs

// *** dv/usr_regs_props.sv ***
`timescale 1ns/100ps
// ****************************************************************
// bus checker for the upper register map
// ****************************************************************
module usr_regs_props (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [15:0] addr_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire usr_pkg::usr_size_e size_i,
    input wire logic sfr_mode_i,
    input wire logic vpp_level_i,
    input wire logic [15:0] rdata_o,
    input wire logic rvalid_o,
    input wire logic err_o,
    input wire logic ext_req_o,
    input wire logic ext_we_o,
    input wire logic [15:0] ext_addr_o,
    input wire logic [7:0] dead_time_o,
    input wire logic [7:0] mem_size_o,
    input wire logic [7:0] xram_size_o,
    input wire logic [7:0] mem_wait_o,
    input wire logic [7:0] wdt_mode_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // window hit, used by both forwarding properties
    logic ext_hit;
    assign ext_hit = addr_i >= 16'hffd0 && addr_i <= 16'hffdf;
    property p_wo_read;
        rd_i && addr_i == 16'hff9a |=> err_o && !rvalid_o;
    endproperty
    a_wo_read: assert property (p_wo_read) else $error("wo read");
    property p_ro_write;
        wr_i && addr_i == 16'hffa1 |=> err_o;
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("ro write");
    property p_baud_bit;
        (rd_i || wr_i) && addr_i == 16'hffa2 && size_i == usr_pkg::USR_BIT
            |=> err_o;
    endproperty
    a_baud_bit: assert property (p_baud_bit) else $error("baud bit");
    property p_ext_sfr;
        (rd_i || wr_i) && ext_hit && sfr_mode_i |=> err_o && !ext_req_o;
    endproperty
    a_ext_sfr: assert property (p_ext_sfr) else $error("ext sfr");
    property p_ext_rd;
        rd_i && ext_hit && !sfr_mode_i && size_i == usr_pkg::USR_BYTE
            |=> ext_req_o && !ext_we_o && ext_addr_o == $past(addr_i)
            ##1 rvalid_o;
    endproperty
    a_ext_rd: assert property (p_ext_rd) else $error("ext read");
    property p_vpp;
        rd_i && addr_i == 16'hff89 && size_i == usr_pkg::USR_BYTE
            |=> rvalid_o && rdata_o[2] == $past(vpp_level_i);
    endproperty
    a_vpp: assert property (p_vpp) else $error("vpp bit");
    property p_cfg_rst;
        $rose(rst_b_i) |-> mem_size_o == 8'hcf && xram_size_o == 8'h0c
            && mem_wait_o == 8'h10 && wdt_mode_o == 8'h00
            && dead_time_o == 8'hff;
    endproperty
    a_cfg_rst: assert property (p_cfg_rst) else $error("cfg reset");
    property p_ims_bit;
        wr_i && addr_i == 16'hfff0 && size_i == usr_pkg::USR_BIT
            |=> err_o && $stable(mem_size_o);
    endproperty
    a_ims_bit: assert property (p_ims_bit) else $error("ims bit");
endmodule : usr_regs_props

bind usr_regs usr_regs_props chk_u (.clk_i, .rst_b_i, .addr_i, .wr_i,
    .rd_i, .size_i, .sfr_mode_i, .vpp_level_i, .rdata_o, .rvalid_o, .err_o,
    .ext_req_o, .ext_we_o, .ext_addr_o, .dead_time_o, .mem_size_o,
    .xram_size_o, .mem_wait_o, .wdt_mode_o);

// *** dv/usr_regs_tb_top.sv ***
`timescale 1ns/100ps
// ****************************************************************
// register map testbench
// ****************************************************************
module usr_regs_tb_top;
    localparam usr_pkg::usr_size_e sz_bit = usr_pkg::USR_BIT;
    localparam usr_pkg::usr_size_e sz_byte = usr_pkg::USR_BYTE;
    localparam usr_pkg::usr_size_e sz_word = usr_pkg::USR_WORD;
    logic clk_i, rst_b_i, wr_i, rd_i, sfr_mode_i, vpp_level_i;
    logic [15:0] addr_i, wdata_i, rdata_o, ext_addr_o;
    logic [2:0] bit_sel_i;
    logic [7:0] ext_wdata_o, ext_wmask_o, dead_time_o, mem_size_o;
    logic [7:0] xram_size_o, mem_wait_o, wdt_mode_o;
    logic rvalid_o, err_o, ext_req_o, ext_we_o;
    usr_pkg::usr_size_e size_i;
    int bad_count = 0;
    int check_count = 0;
    usr_regs dut_u (.clk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .size_i, .bit_sel_i, .sfr_mode_i, .vpp_level_i,
        .async_state_0_i(8'ha5), .async_state_1_i(8'h5a),
        .ext_rdata_i(8'h3c), .rdata_o, .rvalid_o, .err_o, .ext_req_o,
        .ext_we_o, .ext_addr_o, .ext_wdata_o, .ext_wmask_o, .dead_time_o,
        .mem_size_o, .xram_size_o, .mem_wait_o, .wdt_mode_o);
    // 20 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    task automatic chk(input string n, input logic [15:0] s, x);
        check_count++;
        if (s !== x) begin
            bad_count++;
            $display("CHECK FAILED %s exp %h seen %h", n, x, s);
        end
    endtask : chk
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : stop_test
    // one access; bit number rides in d[10:8]; waits a bounded time
    task automatic xfer(input logic w, input logic [15:0] a, d,
        input usr_pkg::usr_size_e s, input logic e, input logic [15:0] x);
        int i;
        @(posedge clk_i);
        wr_i <= w;
        rd_i <= !w;
        addr_i <= a;
        wdata_i <= d;
        size_i <= s;
        bit_sel_i <= d[10:8];
        @(posedge clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        #1;
        for (i = 0; i < 3 && !(w && !e) && rvalid_o !== 1'b1
            && err_o !== 1'b1; i++) begin
            @(posedge clk_i);
            #1;
        end
        if (i == 3) begin
            bad_count++;
            stop_test();
        end
        chk($sformatf("err %h", a), {15'h0, err_o}, {15'h0, e});
        if (!w && !e) chk($sformatf("data %h", a), rdata_o, x);
    endtask : xfer
    // main sequence
    initial begin
        {rst_b_i, wr_i, rd_i, sfr_mode_i, vpp_level_i} = '0;
        {addr_i, wdata_i, bit_sel_i} = '0;
        size_i = sz_byte;
        repeat (5) @(posedge clk_i);
        rst_b_i <= 1'b1;
        // reset values seen through the bus
        xfer(0, 16'hff86, 0, sz_byte, 0, 16'h0000);
        xfer(0, 16'hff89, 0, sz_byte, 0, 16'h0008);
        xfer(0, 16'hff91, 0, sz_byte, 0, 16'h0000);
        xfer(0, 16'hff92, 0, sz_word, 0, 16'h0000);
        xfer(0, 16'hff98, 0, sz_word, 0, 16'h00ff);
        xfer(0, 16'hffe0, 0, sz_word, 0, 16'h0000);
        xfer(0, 16'hffe4, 0, sz_word, 0, 16'hffff);
        xfer(0, 16'hffe8, 0, sz_word, 0, 16'hffff);
        xfer(0, 16'hffea, 0, sz_byte, 0, 16'h00ff);
        xfer(0, 16'hfff0, 0, sz_byte, 0, 16'h00cf);
        xfer(0, 16'hfff4, 0, sz_byte, 0, 16'h000c);
        xfer(0, 16'hfff8, 0, sz_byte, 0, 16'h0010);
        xfer(0, 16'hfffa, 0, sz_byte, 0, 16'h0004);
        chk("dead time", {8'h0, dead_time_o}, 16'h00ff);
        $display("test reset done");
        // refused widths and directions
        xfer(0, 16'hff92, 0, sz_bit, 1, 0);
        xfer(0, 16'hff9a, 0, sz_byte, 1, 0);
        xfer(1, 16'hffa1, 16'h0011, sz_byte, 1, 0);
        xfer(0, 16'hffa1, 0, sz_byte, 0, 16'h00a5);
        xfer(1, 16'hffaa, 16'h0100, sz_bit, 1, 0);
        xfer(1, 16'hfff0, 16'h0100, sz_bit, 1, 0);
        xfer(0, 16'hffea, 16'h0000, sz_word, 1, 0);
        $display("test refusals done");
        // stores, bit writes and side effects
        xfer(1, 16'hff98, 16'h1234, sz_word, 0, 0);
        xfer(0, 16'hff99, 0, sz_byte, 0, 16'h0012);
        xfer(1, 16'hff90, 16'h0301, sz_bit, 0, 0);
        xfer(0, 16'hff90, 0, sz_byte, 0, 16'h0008);
        xfer(1, 16'hffa0, 16'h0701, sz_bit, 0, 0);
        xfer(0, 16'hffa0, 16'h0700, sz_bit, 0, 16'h0001);
        xfer(1, 16'hff9a, 16'h005a, sz_byte, 0, 0);
        chk("dead time", {8'h0, dead_time_o}, 16'h005a);
        xfer(1, 16'hfff0, 16'h00c4, sz_byte, 0, 0);
        chk("mem size", {8'h0, mem_size_o}, 16'h00c4);
        xfer(1, 16'hfff4, 16'h000a, sz_byte, 0, 0);
        chk("xram size", {8'h0, xram_size_o}, 16'h000a);
        vpp_level_i <= 1'b1;
        xfer(0, 16'hff89, 0, sz_byte, 0, 16'h000c);
        xfer(1, 16'hffbd, 16'h0077, sz_byte, 0, 0);
        xfer(0, 16'hffbd, 0, sz_byte, 0, 16'h0000);
        $display("test stores done");
        // external window: direct forwards, register addressing refused
        xfer(0, 16'hffd3, 0, sz_byte, 0, 16'h003c);
        chk("ext addr", ext_addr_o, 16'hffd3);
        xfer(1, 16'hffd5, 16'h0201, sz_bit, 0, 0);
        chk("ext we", {15'h0, ext_we_o}, 16'h0001);
        chk("ext mask", {8'h0, ext_wmask_o}, 16'h0004);
        chk("ext wdata", {8'h0, ext_wdata_o}, 16'h00ff);
        sfr_mode_i <= 1'b1;
        xfer(0, 16'hffd3, 0, sz_byte, 1, 0);
        sfr_mode_i <= 1'b0;
        $display("test window done");
        stop_test();
    end
endmodule : usr_regs_tb_top
